// File: rtl/smmio_pkg.sv
// Constants shared by both ends of the I/O trap restart link
// Functional notes
// - Restart word at fixed offset, upper half reserved
// - 0000h continues next, 00FFh repeats trapped I/O
// - Restart word cleared on every management entry
// - Trap dword validity flag updated on trapped entry
// - Handler checks validity before touching restart word
// - Resume with 00FFh re-executes trapped I/O
// - Handler never writes word when flag invalid
// - New interrupt serviced before pending re-execution
// - Nested entry never valid; handler leaves word alone
// - Debug trap held until management mode exits
// - Debug control regs kept; breakpoint regs by handler
// - Held debug trap follows repeated I/O completion
// - During I/O trap, interrupt sampling beats debug
// - Non-maskable request accepted only after interrupt return
// - Then stays enabled; prior masking restored on exit
// - Valid flag means interrupt hit during I/O
// - Save-area offsets relative to current base
package smmio_pkg;
   localparam logic [15:0] OFF_RESTART = 16'hff00;
   localparam logic [15:0] OFF_TRAP = 16'hffa4;
   localparam logic [15:0] OFF_BASE = 16'hfef8;
   localparam logic [15:0] RESTART_NEXT = 16'h0000;
   localparam logic [15:0] RESTART_AGAIN = 16'h00ff;
   localparam int TRAP_VALID_BIT = 1;
   localparam int TRAP_PORT_LSB = 16;
   localparam logic [31:0] BASE_RESET = 32'h0003_0000;
   localparam logic [3:0] IRQ_HOLD_CYCLES = 4'h2;
   // Controller register map
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_TRAP = 8'h08;
   localparam logic [7:0] APB_INT_STATUS = 8'h0c;
   localparam logic [7:0] APB_INT_MASK = 8'h10;
   localparam int CTRL_RAISE = 0;
   localparam int CTRL_RESUME = 1;
   localparam int CTRL_IRQ_RET = 2;
   localparam int CTRL_WANT_RESTART = 3;
   localparam int INT_ENTERED = 0;
   localparam int INT_EXITED = 1;
endpackage : smmio_pkg

// File: rtl/smmio_if.sv
// Link between the processor trap unit and the system logic
`timescale 1ns/10ps
`default_nettype none
interface smmio_if;
   logic sysmgmtIrqN;
   logic mgmtActive;
   logic saveReq;
   logic saveWrite;
   logic [31:0] saveAddr;
   logic [31:0] saveWdata;
   logic [31:0] saveRdata;
   logic saveAck;
   logic resumeInstr;
   logic irqReturnInstr;
   modport dev (input sysmgmtIrqN, output mgmtActive, input saveReq, input saveWrite,
      input saveAddr, input saveWdata, output saveRdata, output saveAck,
      input resumeInstr, input irqReturnInstr);
   modport sys (output sysmgmtIrqN, input mgmtActive, output saveReq, output saveWrite,
      output saveAddr, output saveWdata, input saveRdata, input saveAck,
      output resumeInstr, output irqReturnInstr);
endinterface : smmio_if
`default_nettype wire

// File: rtl/smmio_trap_unit.sv
// Processor side: trap capture, restart slot, debug and NMI gating
`timescale 1ns/10ps
`default_nettype none
module smmio_trap_unit (
   input wire logic sys_clk,
   input wire logic rst_n,
   smmio_if.dev link,
   input wire logic ioActive,
   input wire logic [15:0] ioPortAddr,
   input wire logic ioIsInput,
   input wire logic ioIsString,
   input wire logic ioIsRep,
   input wire logic ioRepeatDone,
   input wire logic debugTrapReq,
   input wire logic nmiReq,
   input wire logic nmiMaskIn,
   output logic mgmtMode,
   output logic reexecIo,
   output logic continueNext,
   output logic debugTrapTake,
   output logic nmiTake,
   output logic nmiMask
);
   typedef enum logic {SMMIO_RUN, SMMIO_MGMT} smmio_mode_t;

   typedef struct packed {
      smmio_mode_t mode;
      logic irqPrev;
      logic irqPend;
      logic [15:0] restartWord;
      logic [31:0] trapDword;
      logic [31:0] smmBase;
      logic nested;
      logic reexecPending;
      logic reexecAwait;
      logic debugHeld;
      logic nmiEnabled;
      logic nmiSaved;
      logic nmiMask;
      logic ack;
      logic [31:0] rdata;
      logic reexecIo;
      logic continueNext;
      logic debugTrapTake;
      logic nmiTake;
   } smmio_dev_state_t;

   smmio_dev_state_t cur;
   smmio_dev_state_t next_cur;

   localparam logic [15:0] RESTART_NEXT_W = smmio_pkg::RESTART_NEXT;
   localparam logic [15:0] RESTART_AGAIN = smmio_pkg::RESTART_AGAIN;
   localparam logic [15:0] OFF_RESTART = smmio_pkg::OFF_RESTART;
   localparam logic [15:0] OFF_TRAP = smmio_pkg::OFF_TRAP;
   localparam logic [15:0] OFF_BASE = smmio_pkg::OFF_BASE;
   localparam logic [31:0] BASE_RESET_W = smmio_pkg::BASE_RESET;

   function automatic logic [15:0] smmioOffset(input logic [31:0] addr,
                                               input logic [31:0] base);
      logic [31:0] diff;
      diff = addr - base;
      smmioOffset = (diff[31:16] == 16'h0000) ? diff[15:0] : 16'h0000;
   endfunction : smmioOffset

   ////////////////////////////////////////////////////////////////////////////
   logic irqEdge;
   logic normalDebugFirst;
   logic nestedEntry;
   logic [15:0] accOff;

   always_comb
   begin
      irqEdge = cur.irqPrev & ~link.sysmgmtIrqN;
      // Outside an I/O trap a debug trap outranks interrupt sampling
      // Requests drop a cycle after their take, so never deliver one twice
      normalDebugFirst = debugTrapReq & ~ioActive & ~cur.debugHeld & ~cur.debugTrapTake;
      nestedEntry = cur.reexecPending;
      accOff = smmioOffset(link.saveAddr, cur.smmBase);
      next_cur = cur;
      next_cur.irqPrev = link.sysmgmtIrqN;
      next_cur.reexecIo = 1'b0;
      next_cur.continueNext = 1'b0;
      next_cur.debugTrapTake = 1'b0;
      next_cur.nmiTake = 1'b0;
      next_cur.ack = 1'b0;
      if (irqEdge)
      begin
         next_cur.irqPend = 1'b1;
      end
      unique case (cur.mode)
         SMMIO_RUN:
         begin
            if (nmiReq && !cur.nmiMask && !cur.nmiTake)
            begin
               next_cur.nmiTake = 1'b1;
            end
            if (cur.reexecAwait && ioRepeatDone)
            begin
               next_cur.reexecAwait = 1'b0;
               if (cur.debugHeld)
               begin
                  next_cur.debugTrapTake = 1'b1;
                  next_cur.debugHeld = 1'b0;
               end
            end
            if ((cur.irqPend || irqEdge) && !cur.reexecAwait && normalDebugFirst)
            begin
               next_cur.debugTrapTake = 1'b1;
            end
            else if ((cur.irqPend || irqEdge) && !cur.reexecAwait)
            begin
               next_cur.mode = SMMIO_MGMT;
               next_cur.irqPend = 1'b0;
               next_cur.restartWord = RESTART_NEXT_W;
               next_cur.trapDword = {ioPortAddr, 12'h000, ioIsRep, ioIsString,
                  ioActive & ~nestedEntry, ioIsInput};
               next_cur.nested = nestedEntry;
               if (debugTrapReq)
               begin
                  next_cur.debugHeld = 1'b1;
               end
               next_cur.nmiSaved = cur.nmiMask;
               next_cur.nmiMask = 1'b1;
               next_cur.nmiEnabled = 1'b0;
            end
            else if (cur.reexecPending)
            begin
               next_cur.reexecPending = 1'b0;
               next_cur.reexecAwait = 1'b1;
               next_cur.reexecIo = 1'b1;
            end
            else if (debugTrapReq && !cur.reexecAwait && !cur.debugHeld && !cur.debugTrapTake)
            begin
               next_cur.debugTrapTake = 1'b1;
            end
         end
         SMMIO_MGMT:
         begin
            if (link.irqReturnInstr)
            begin
               next_cur.nmiEnabled = 1'b1;
            end
            if (nmiReq && (cur.nmiEnabled || link.irqReturnInstr) && !cur.nmiTake)
            begin
               next_cur.nmiTake = 1'b1;
            end
            if (link.saveReq && !cur.ack)
            begin
               next_cur.ack = 1'b1;
               next_cur.rdata = 32'h0000_0000;
               if (link.saveWrite)
               begin
                  if (accOff == OFF_RESTART)
                  begin
                     // Upper half is reserved and never steers resume
                     next_cur.restartWord = link.saveWdata[15:0];
                  end
                  else if (accOff == OFF_BASE)
                  begin
                     next_cur.smmBase = link.saveWdata;
                  end
               end
               else if (accOff == OFF_RESTART)
               begin
                  next_cur.rdata = {16'h0000, cur.restartWord};
               end
               else if (accOff == OFF_TRAP)
               begin
                  next_cur.rdata = cur.trapDword;
               end
               else if (accOff == OFF_BASE)
               begin
                  next_cur.rdata = cur.smmBase;
               end
            end
            if (link.resumeInstr)
            begin
               next_cur.mode = SMMIO_RUN;
               next_cur.nmiMask = cur.nmiSaved;
               next_cur.nmiEnabled = 1'b0;
               if (cur.nested)
               begin
                  // Outer re-execution still owed; keep it and any held trap
                  next_cur.nested = 1'b0;
               end
               else if (cur.restartWord == RESTART_AGAIN)
               begin
                  next_cur.reexecPending = 1'b1;
               end
               else
               begin
                  next_cur.continueNext = 1'b1;
                  if (cur.debugHeld)
                  begin
                     next_cur.debugTrapTake = 1'b1;
                     next_cur.debugHeld = 1'b0;
                  end
               end
            end
         end
      endcase
      // Debug control state is owned elsewhere and survives untouched here
      if (!rst_n)
      begin
         next_cur = '0;
         next_cur.mode = SMMIO_RUN;
         next_cur.irqPrev = 1'b1;
         next_cur.smmBase = BASE_RESET_W;
         next_cur.nmiMask = nmiMaskIn;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      cur <= next_cur;
   end

   assign link.mgmtActive = (cur.mode == SMMIO_MGMT);
   assign link.saveAck = cur.ack;
   assign link.saveRdata = cur.rdata;
   assign mgmtMode = (cur.mode == SMMIO_MGMT);
   assign reexecIo = cur.reexecIo;
   assign continueNext = cur.continueNext;
   assign debugTrapTake = cur.debugTrapTake;
   assign nmiTake = cur.nmiTake;
   assign nmiMask = cur.nmiMask;
endmodule : smmio_trap_unit
`default_nettype wire

// File: rtl/smmio_sys_ctrl.sv
// System logic side: raises the interrupt and runs the handler steps
`timescale 1ns/10ps
`default_nettype none
module smmio_sys_ctrl (
   input wire logic sys_clk,
   input wire logic rst_n,
   smmio_if.sys link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irqOut
);
   typedef enum logic [2:0] {SMMIO_IDLE, SMMIO_RAISE, SMMIO_WAIT, SMMIO_INSIDE,
      SMMIO_RD_TRAP, SMMIO_WR_RST, SMMIO_RESUME} smmio_ctl_t;

   typedef struct packed {
      smmio_ctl_t st;
      logic [3:0] holdCnt;
      logic irqN;
      logic wantRestart;
      logic [31:0] trapCopy;
      logic restartWritten;
      logic req;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic resume;
      logic irqRet;
      logic activePrev;
      logic [1:0] intStatus;
      logic [1:0] intMask;
      logic [31:0] prdata;
      logic pslverr;
   } smmio_sys_state_t;

   smmio_sys_state_t cur;
   smmio_sys_state_t next_cur;

   ////////////////////////////////////////////////////////////////////////////
   logic setupRd;
   logic accWr;
   logic [7:0] off;
   logic mapped;
   logic [1:0] events;

   always_comb
   begin
      off = paddr[7:0];
      mapped = (paddr[31:8] == 24'h000000) && (off == smmio_pkg::APB_CTRL ||
         off == smmio_pkg::APB_STATUS || off == smmio_pkg::APB_TRAP ||
         off == smmio_pkg::APB_INT_STATUS || off == smmio_pkg::APB_INT_MASK);
      setupRd = psel & ~penable & ~pwrite;
      accWr = psel & penable & pwrite & mapped;
      events = 2'b00;
      events[smmio_pkg::INT_ENTERED] = link.mgmtActive & ~cur.activePrev;
      events[smmio_pkg::INT_EXITED] = ~link.mgmtActive & cur.activePrev;
      next_cur = cur;
      next_cur.activePrev = link.mgmtActive;
      next_cur.resume = 1'b0;
      next_cur.irqRet = 1'b0;
      if (psel && !penable)
      begin
         next_cur.pslverr = ~mapped;
      end
      if (setupRd)
      begin
         next_cur.prdata = 32'h0000_0000;
         if (off == smmio_pkg::APB_STATUS)
         begin
            next_cur.prdata = {29'h0, cur.restartWritten, cur.st != SMMIO_IDLE,
               link.mgmtActive};
         end
         else if (off == smmio_pkg::APB_TRAP)
         begin
            next_cur.prdata = cur.trapCopy;
         end
         else if (off == smmio_pkg::APB_INT_STATUS)
         begin
            next_cur.prdata = {30'h0, cur.intStatus};
         end
         else if (off == smmio_pkg::APB_INT_MASK)
         begin
            next_cur.prdata = {30'h0, cur.intMask};
         end
         else if (off == smmio_pkg::APB_CTRL)
         begin
            next_cur.prdata = {28'h0, cur.wantRestart, 3'h0};
         end
      end
      // Read clears only what it reported; later or same-cycle events still land
      if (psel && penable && !pwrite && off == smmio_pkg::APB_INT_STATUS)
      begin
         next_cur.intStatus = (cur.intStatus & ~cur.prdata[1:0]) | events;
      end
      else
      begin
         next_cur.intStatus = cur.intStatus | events;
      end
      if (accWr && off == smmio_pkg::APB_INT_MASK)
      begin
         next_cur.intMask = pwdata[1:0];
      end
      if (accWr && off == smmio_pkg::APB_CTRL)
      begin
         next_cur.wantRestart = pwdata[smmio_pkg::CTRL_WANT_RESTART];
      end
      unique case (cur.st)
         SMMIO_IDLE:
         begin
            if (accWr && off == smmio_pkg::APB_CTRL && pwdata[smmio_pkg::CTRL_RAISE])
            begin
               next_cur.st = SMMIO_RAISE;
               next_cur.irqN = 1'b0;
               next_cur.holdCnt = 4'h1;
            end
         end
         SMMIO_RAISE:
         begin
            // Edge input: held low long enough to be sampled
            if (cur.holdCnt >= smmio_pkg::IRQ_HOLD_CYCLES)
            begin
               next_cur.irqN = 1'b1;
               next_cur.st = SMMIO_WAIT;
            end
            else
            begin
               next_cur.holdCnt = cur.holdCnt + 4'h1;
            end
         end
         SMMIO_WAIT:
         begin
            if (link.mgmtActive)
            begin
               next_cur.st = SMMIO_INSIDE;
               next_cur.restartWritten = 1'b0;
            end
         end
         SMMIO_INSIDE:
         begin
            if (accWr && off == smmio_pkg::APB_CTRL && pwdata[smmio_pkg::CTRL_IRQ_RET])
            begin
               next_cur.irqRet = 1'b1;
            end
            else if (accWr && off == smmio_pkg::APB_CTRL &&
               pwdata[smmio_pkg::CTRL_RESUME])
            begin
               next_cur.st = SMMIO_RD_TRAP;
               next_cur.req = 1'b1;
               next_cur.wr = 1'b0;
               next_cur.addr = smmio_pkg::BASE_RESET + {16'h0000, smmio_pkg::OFF_TRAP};
            end
         end
         SMMIO_RD_TRAP:
         begin
            if (link.saveAck)
            begin
               next_cur.req = 1'b0;
               next_cur.trapCopy = link.saveRdata;
               // Only a valid trap may request a repeat; nested entries never are
               if (cur.wantRestart && link.saveRdata[smmio_pkg::TRAP_VALID_BIT])
               begin
                  next_cur.st = SMMIO_WR_RST;
               end
               else
               begin
                  next_cur.st = SMMIO_RESUME;
               end
            end
         end
         SMMIO_WR_RST:
         begin
            if (!cur.req)
            begin
               next_cur.req = 1'b1;
               next_cur.wr = 1'b1;
               next_cur.addr = smmio_pkg::BASE_RESET + {16'h0000, smmio_pkg::OFF_RESTART};
               next_cur.wdata = {16'h0000, smmio_pkg::RESTART_AGAIN};
            end
            else if (link.saveAck)
            begin
               next_cur.req = 1'b0;
               next_cur.wr = 1'b0;
               next_cur.restartWritten = 1'b1;
               next_cur.st = SMMIO_RESUME;
            end
         end
         SMMIO_RESUME:
         begin
            next_cur.resume = 1'b1;
            next_cur.st = SMMIO_IDLE;
         end
         default:
         begin
            next_cur.st = SMMIO_IDLE;
         end
      endcase
      if (!rst_n)
      begin
         next_cur = '0;
         next_cur.st = SMMIO_IDLE;
         next_cur.irqN = 1'b1;
         next_cur.activePrev = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      cur <= next_cur;
   end

   // Zero wait state slave keeps the master simple
   assign pready = 1'b1;
   assign prdata = cur.prdata;
   assign pslverr = cur.pslverr;
   assign irqOut = |(cur.intStatus & cur.intMask);
   assign link.sysmgmtIrqN = cur.irqN;
   assign link.saveReq = cur.req;
   assign link.saveWrite = cur.wr;
   assign link.saveAddr = cur.addr;
   assign link.saveWdata = cur.wdata;
   assign link.resumeInstr = cur.resume;
   assign link.irqReturnInstr = cur.irqRet;
endmodule : smmio_sys_ctrl
`default_nettype wire

// File: dv/smmio_link_props.sv
// Concurrent checks on the link between trap unit and system logic
`timescale 1ns/10ps
`default_nettype none
module smmio_link_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sysmgmtIrqN,
   input wire logic mgmtActive,
   input wire logic saveReq,
   input wire logic saveWrite,
   input wire logic [31:0] saveAddr,
   input wire logic [31:0] saveWdata,
   input wire logic [31:0] saveRdata,
   input wire logic saveAck,
   input wire logic resumeInstr
);
   // Controller always works at the reset base
   localparam logic [31:0] RESTART_A = {16'h0003, smmio_pkg::OFF_RESTART};
   localparam logic [31:0] TRAP_A = {16'h0003, smmio_pkg::OFF_TRAP};
   logic prevAct;
   logic wrote;
   logic validSeen;
   logic nested;
   logic [2:0] resHist;
   wire logic rdAck = saveAck && !saveWrite;
   ////////////////////////////////////////////////////////////////////////////////
   // Entry within a few cycles of resume after a restart write counts as nested
   always_ff @(posedge sys_clk)
   begin
      prevAct <= mgmtActive;
      resHist <= rst_n ? {resHist[1:0], resumeInstr} : 3'h0;
      if (!rst_n)
      begin
         wrote <= 1'b0;
         validSeen <= 1'b0;
         nested <= 1'b0;
      end
      else if (mgmtActive && !prevAct)
      begin
         nested <= wrote && (resHist != 3'h0);
         wrote <= 1'b0;
         validSeen <= 1'b0;
      end
      else
      begin
         wrote <= wrote || (saveAck && saveWrite && saveAddr == RESTART_A);
         validSeen <= validSeen || (rdAck && saveAddr == TRAP_A && saveRdata[1]);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence exit_s;
      ##1 !mgmtActive;
   endsequence
   sequence irq_low_s;
      !sysmgmtIrqN [*2];
   endsequence
   entry_time_a: assert property ($fell(sysmgmtIrqN) && !mgmtActive |->
      ##[1:8] mgmtActive)
      else $error("management entry late");
   irq_hold_a: assert property ($fell(sysmgmtIrqN) |-> irq_low_s)
      else $error("interrupt request too short");
   ack_time_a: assert property (saveReq && !saveAck && mgmtActive |=> saveAck)
      else $error("save access not acknowledged");
   base_rel_a: assert property (saveReq |-> saveAddr[31:16] == 16'h0003)
      else $error("save access outside base window");
   valid_first_a: assert property (saveReq && saveWrite && saveAddr == RESTART_A |->
      validSeen && saveWdata == 32'h0000_00ff)
      else $error("restart word written without valid trap");
   nested_invalid_a: assert property (rdAck && saveAddr == TRAP_A && nested |->
      !saveRdata[1])
      else $error("nested entry reports valid trap");
   nested_nowrite_a: assert property (saveReq && saveWrite && nested |->
      saveAddr != RESTART_A)
      else $error("nested handler wrote restart word");
   resume_exit_a: assert property (resumeInstr |-> exit_s)
      else $error("resume did not leave management mode");
endmodule : smmio_link_props
`default_nettype wire

// File: dv/smm_io_trap_restart_bench.sv
// Self-checking bench for the trap restart link, both ends
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module smm_io_trap_restart_bench;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irqOut;
   logic ioActive = 1'b0;
   logic [15:0] ioPortAddr = 16'h0;
   logic ioIsInput = 1'b0;
   logic ioIsString = 1'b0;
   logic ioIsRep = 1'b0;
   logic ioRepeatDone = 1'b0;
   logic debugTrapReq = 1'b0;
   logic nmiReq = 1'b0;
   logic nmiMaskIn = 1'b1;
   logic mgmtMode, reexecIo, continueNext, debugTrapTake, nmiTake, nmiMask;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int nReexec = 0;
   int nCont = 0;
   int nDbg = 0;
   int nNmi = 0;
   smmio_if link ();
   smmio_trap_unit smmio_trap_unit_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
      .ioActive(ioActive), .ioPortAddr(ioPortAddr), .ioIsInput(ioIsInput),
      .ioIsString(ioIsString), .ioIsRep(ioIsRep), .ioRepeatDone(ioRepeatDone),
      .debugTrapReq(debugTrapReq), .nmiReq(nmiReq), .nmiMaskIn(nmiMaskIn),
      .mgmtMode(mgmtMode), .reexecIo(reexecIo), .continueNext(continueNext),
      .debugTrapTake(debugTrapTake), .nmiTake(nmiTake), .nmiMask(nmiMask));
   smmio_sys_ctrl smmio_sys_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqOut(irqOut));
   smmio_link_props smmio_link_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .sysmgmtIrqN(link.sysmgmtIrqN), .mgmtActive(link.mgmtActive), .saveReq(link.saveReq),
      .saveWrite(link.saveWrite), .saveAddr(link.saveAddr), .saveWdata(link.saveWdata),
      .saveRdata(link.saveRdata), .saveAck(link.saveAck), .resumeInstr(link.resumeInstr));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #25 sys_clk = ~sys_clk;
   end
   // Pulses are counted, so a late check still sees them; requests drop once taken
   always @(posedge sys_clk)
   begin
      cycles++;
      nReexec += int'(reexecIo === 1'b1);
      nCont += int'(continueNext === 1'b1);
      nDbg += int'(debugTrapTake === 1'b1);
      nNmi += int'(nmiTake === 1'b1);
      if (debugTrapTake === 1'b1)
         debugTrapReq <= 1'b0;
      if (nmiTake === 1'b1)
         nmiReq <= 1'b0;
      if (cycles == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_mode(input logic v);
      int k;
      k = 0;
      while (mgmtMode !== v && k < 40)
      begin
         @(posedge sys_clk);
         k++;
      end
      `CHK(mgmtMode, v)
   endtask : wait_mode
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, smmio_pkg::APB_STATUS, 32'h0);
      `CHK({rd, irqOut, mgmtMode}, {32'h0, 1'b0, 1'b0})
      `CHK(nmiMask, 1'b1)
      // Trapped input, handler continues with the next instruction
      ioActive <= 1'b1;
      ioPortAddr <= 16'h1234;
      ioIsInput <= 1'b1;
      ioIsRep <= 1'b1;
      apb(1'b1, smmio_pkg::APB_INT_MASK, 32'h3);
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h1);
      wait_mode(1'b1);
      ioActive <= 1'b0;
      // Status bit lands one cycle after entry
      @(posedge sys_clk);
      `CHK(irqOut, 1'b1)
      apb(1'b0, smmio_pkg::APB_INT_STATUS, 32'h0);
      `CHK(rd, 32'h1)
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h2);
      wait_mode(1'b0);
      apb(1'b0, smmio_pkg::APB_TRAP, 32'h0);
      `CHK(rd, 32'h1234_000b)
      `CHK({nCont, nReexec}, {32'sd1, 32'sd0})
      $display("test continue done");
      // Trapped string output with a debug trap pending, handler asks for repeat
      ioActive <= 1'b1;
      ioPortAddr <= 16'h00a5;
      ioIsInput <= 1'b0;
      ioIsString <= 1'b1;
      ioIsRep <= 1'b0;
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h9);
      // Debug trap coincides with the edge the trap unit sees
      debugTrapReq <= 1'b1;
      wait_mode(1'b1);
      ioActive <= 1'b0;
      `CHK(nDbg, 0)
      apb(1'b1, smmio_pkg::APB_CTRL, 32'ha);
      wait_mode(1'b0);
      repeat (4) @(posedge sys_clk);
      `CHK(nReexec, 1)
      `CHK(nDbg, 0)
      ioRepeatDone <= 1'b1;
      @(posedge sys_clk);
      ioRepeatDone <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK({nDbg, nCont}, {32'sd1, 32'sd1})
      apb(1'b0, smmio_pkg::APB_TRAP, 32'h0);
      `CHK(rd, 32'h00a5_0006)
      $display("test repeat done");
      // No I/O in flight: restart must not be written, old repeat code gone
      apb(1'b1, smmio_pkg::APB_INT_MASK, 32'h0);
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h9);
      wait_mode(1'b1);
      `CHK(irqOut, 1'b0)
      apb(1'b1, smmio_pkg::APB_CTRL, 32'ha);
      wait_mode(1'b0);
      repeat (4) @(posedge sys_clk);
      `CHK({nReexec, nCont}, {32'sd1, 32'sd2})
      apb(1'b0, smmio_pkg::APB_STATUS, 32'h0);
      `CHK(rd[2], 1'b0)
      apb(1'b0, smmio_pkg::APB_TRAP, 32'h0);
      `CHK(rd[1], 1'b0)
      apb(1'b0, smmio_pkg::APB_INT_STATUS, 32'h0);
      `CHK(rd, 32'h3)
      $display("test invalid done");
      // NMI held off inside until interrupt return, then stays open
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h1);
      wait_mode(1'b1);
      nmiReq <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK(nNmi, 0)
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h4);
      repeat (4) @(posedge sys_clk);
      `CHK(nNmi, 1)
      nmiReq <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK(nNmi, 2)
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h2);
      wait_mode(1'b0);
      `CHK(nmiMask, 1'b1)
      // Unmapped register place
      apb(1'b1, 8'h20, 32'hffff_ffff);
      `CHK(err, 1'b1)
      apb(1'b0, 8'h20, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test nmi and unmapped done");
      // Second interrupt lands on the resume edge, ahead of the owed repeat
      ioActive <= 1'b1;
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h9);
      wait_mode(1'b1);
      ioActive <= 1'b0;
      apb(1'b1, smmio_pkg::APB_CTRL, 32'ha);
      repeat (4) @(posedge sys_clk);
      apb(1'b1, smmio_pkg::APB_CTRL, 32'h9);
      repeat (3) @(posedge sys_clk);
      `CHK({mgmtMode, nReexec}, {1'b1, 32'sd1})
      apb(1'b1, smmio_pkg::APB_CTRL, 32'ha);
      wait_mode(1'b0);
      repeat (4) @(posedge sys_clk);
      `CHK(nReexec, 2)
      apb(1'b0, smmio_pkg::APB_TRAP, 32'h0);
      `CHK(rd[1], 1'b0)
      apb(1'b0, smmio_pkg::APB_STATUS, 32'h0);
      `CHK(rd[2], 1'b0)
      $display("test nested done");
      print_verdict();
   end
endmodule : smm_io_trap_restart_bench
`default_nettype wire
